// *** cmp_core_mode.sv ***
// Purpose: core control register, mode outputs and program address checks
// Assumes: register port strobes are synchronous to core_clk
// Notes: the rounding and multiply datapath is a small example lane
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cmp_core_mode (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] ea_in,
  input wire logic ea_is_stack,
  input wire logic ea_is_write,
  output logic [23:0] data_addr,
  output logic data_flat,
  input wire logic [22:0] program_counter,
  input wire logic pgm_table_read,
  input wire logic [15:0] table_offset,
  output logic [23:0] pgm_addr,
  output logic pgm_allowed,
  input wire logic user_irq_req,
  input wire logic [3:0] user_irq_level,
  output logic irq_take,
  output logic [3:0] cpu_priority,
  input wire logic signed [15:0] mul_a,
  input wire logic signed [15:0] mul_b,
  output logic signed [31:0] mul_product,
  output logic [15:0] mul_rounded
);
  import cmp_pkg::*;

  logic [15:0] core_control_q; // mode bits
  logic [2:0] priority_level_low_q; // status word bits 7..5
  logic [7:0] table_page_q; // table page register
  logic [9:0] data_read_page_q; // read page register
  logic [9:0] data_write_page_q; // write page register
  logic stack_frame_active, rounding_select, int_mode, priority_level_high;

  assign stack_frame_active = core_control_q[CMP_FRAME_BIT];
  assign rounding_select = core_control_q[CMP_ROUND_SEL_BIT];
  assign int_mode = core_control_q[CMP_INT_MODE_BIT];
  assign priority_level_high = core_control_q[CMP_PLH_BIT];

  // address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // core control register writes take effect on the next cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      core_control_q <= CMP_CORE_CONTROL_RST;
    end else if (reg_wr && hit(reg_addr, CMP_CORE_CONTROL_OFS)) begin
      core_control_q <= reg_wdata & CMP_CORE_CONTROL_WMASK;
    end
  end

  // status word priority bits
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      priority_level_low_q <= CMP_PRIO_LOW_RST;
    end else if (reg_wr && hit(reg_addr, CMP_STATUS_OFS)) begin
      priority_level_low_q <= reg_wdata[7:5];
    end
  end

  // page registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      table_page_q <= CMP_TABLE_PAGE_RST;
      data_read_page_q <= CMP_PAGE_RST;
      data_write_page_q <= CMP_PAGE_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, CMP_TABLE_PAGE_OFS)) begin
        table_page_q <= reg_wdata[7:0];
      end
      if (hit(reg_addr, CMP_READ_PAGE_OFS)) begin
        data_read_page_q <= reg_wdata[9:0];
      end
      if (hit(reg_addr, CMP_WRITE_PAGE_OFS)) begin
        data_write_page_q <= reg_wdata[9:0];
      end
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        CMP_CORE_CONTROL_OFS: reg_rdata <= core_control_q;
        CMP_STATUS_OFS: reg_rdata <= {8'h00, priority_level_low_q, 5'h00};
        CMP_TABLE_PAGE_OFS: reg_rdata <= {8'h00, table_page_q};
        CMP_READ_PAGE_OFS: reg_rdata <= {6'h00, data_read_page_q};
        CMP_WRITE_PAGE_OFS: reg_rdata <= {6'h00, data_write_page_q};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // data address: stack pointers flat when frame active, else paged in the upper half
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      data_addr <= 24'h000000;
      data_flat <= 1'b0;
    end else if (ea_is_stack && stack_frame_active) begin
      data_addr <= {8'h00, ea_in};
      data_flat <= 1'b1;
    end else if (ea_in[15]) begin
      // upper half goes through the page registers
      data_addr <= ea_is_write ? {data_write_page_q[8:0], ea_in[14:0]}
                               : {data_read_page_q[8:0], ea_in[14:0]};
      data_flat <= 1'b0;
    end else begin
      data_addr <= {8'h00, ea_in};
      data_flat <= 1'b0;
    end
  end

  // program address: counter or table page, with user half check
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pgm_addr <= 24'h000000;
      pgm_allowed <= 1'b0;
    end else if (pgm_table_read) begin
      pgm_addr <= {table_page_q, table_offset};
      // lower half as usual, or the identification area when the page bit is set
      pgm_allowed <= ({table_page_q, table_offset} <= CMP_USER_LIMIT) ||
                     table_page_q[CMP_TBL_ID_BIT];
    end else begin
      pgm_addr <= {program_counter, 1'b0};
      pgm_allowed <= ({program_counter, 1'b0} <= CMP_USER_LIMIT);
    end
  end

  // priority level and user interrupt gate
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cpu_priority <= 4'h0;
      irq_take <= 1'b0;
    end else begin
      cpu_priority <= {priority_level_high, priority_level_low_q};
      irq_take <= user_irq_req && !priority_level_high &&
                  (user_irq_level > {1'b0, priority_level_low_q});
    end
  end

  // multiply lane: fractional shifts left one, integer keeps product
  logic signed [31:0] prod_raw;
  logic [15:0] hi_word, lo_word;
  logic round_up;
  always_comb begin
    prod_raw = mul_a * mul_b;
    if (!int_mode) begin
      prod_raw = prod_raw <<< 1;
    end
    hi_word = prod_raw[31:16];
    lo_word = prod_raw[15:0];
    if (rounding_select) begin
      round_up = lo_word[15];
    end else if (lo_word == 16'h8000) begin
      round_up = hi_word[0];
    end else begin
      round_up = lo_word[15];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mul_product <= 32'sh0;
      mul_rounded <= 16'h0000;
    end else begin
      mul_product <= prod_raw;
      mul_rounded <= hi_word + {15'h0000, round_up};
    end
  end

  // assertions
  a_ctrl_write_visible: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == CMP_CORE_CONTROL_OFS ##1 reg_rd && reg_addr == CMP_CORE_CONTROL_OFS
    |=> reg_rdata == ($past(reg_wdata, 2) & CMP_CORE_CONTROL_WMASK))
    else $error("core control readback wrong");
  a_flat_stack_addr: assert property (@(posedge core_clk) disable iff (reset)
    ea_is_stack && stack_frame_active |=> data_flat && data_addr == {8'h00, $past(ea_in)})
    else $error("stack access not flat");
  a_paged_stack_addr: assert property (@(posedge core_clk) disable iff (reset)
    ea_is_stack && !stack_frame_active |=> !data_flat)
    else $error("stack access flat while frame clear");
  a_prio_concat: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> cpu_priority == {$past(priority_level_high), $past(priority_level_low_q)})
    else $error("priority level wrong");
  a_prio_blocks_irq: assert property (@(posedge core_clk) disable iff (reset)
    priority_level_high |=> !irq_take)
    else $error("user interrupt taken at high level");
  a_user_half_limit: assert property (@(posedge core_clk) disable iff (reset)
    !pgm_table_read && program_counter[22] |=> !pgm_allowed)
    else $error("upper half allowed");
  a_pc_addr_form: assert property (@(posedge core_clk) disable iff (reset)
    !pgm_table_read |=> pgm_addr == {$past(program_counter), 1'b0})
    else $error("program address wrong");
  a_int_product: assert property (@(posedge core_clk) disable iff (reset)
    int_mode |=> mul_product == $past(mul_a) * $past(mul_b))
    else $error("integer product wrong");
  a_frac_product: assert property (@(posedge core_clk) disable iff (reset)
    !int_mode |=> mul_product == (($past(mul_a) * $past(mul_b)) <<< 1))
    else $error("fractional product wrong");

  // true for any offset that the register port decodes
  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, CMP_CORE_CONTROL_OFS) || hit(a, CMP_STATUS_OFS) ||
             hit(a, CMP_TABLE_PAGE_OFS) || hit(a, CMP_READ_PAGE_OFS) ||
             hit(a, CMP_WRITE_PAGE_OFS);
  endfunction

  // a software write to the core control register
  sequence s_ctrl_write;
    reg_wr && reg_addr == CMP_CORE_CONTROL_OFS;
  endsequence

  // a control write that turns the stack frame on
  sequence s_frame_on;
    reg_wr && reg_addr == CMP_CORE_CONTROL_OFS && reg_wdata[CMP_FRAME_BIT];
  endsequence

  // a control write that raises the priority level high bit
  sequence s_prio_high_on;
    reg_wr && reg_addr == CMP_CORE_CONTROL_OFS && reg_wdata[CMP_PLH_BIT];
  endsequence

  // a control write that selects integer multiply
  sequence s_int_on;
    reg_wr && reg_addr == CMP_CORE_CONTROL_OFS && reg_wdata[CMP_INT_MODE_BIT];
  endsequence

  // a data access through either stack pointer
  sequence s_stack_access;
    ea_is_stack;
  endsequence

  // a user request for an interrupt
  sequence s_user_request;
    user_irq_req;
  endsequence

  // the control register only changes on its own write
  a_ctrl_hold: assert property (@(posedge core_clk) disable iff (reset)
    !(reg_wr && reg_addr == CMP_CORE_CONTROL_OFS) |=> $stable(core_control_q))
    else $error("core control changed without a write");

  // a control write lands masked in the next cycle
  a_ctrl_write_lands: assert property (@(posedge core_clk) disable iff (reset)
    s_ctrl_write |=> core_control_q == ($past(reg_wdata) & CMP_CORE_CONTROL_WMASK))
    else $error("core control write lost");

  // unused control bits read back as zero
  a_ctrl_upper_zero: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_addr == CMP_CORE_CONTROL_OFS |=> reg_rdata[15:4] == 12'h000)
    else $error("unused control bits read as one");

  // read data is zero outside the cycle after a read
  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");

  // reads of undecoded offsets return zero
  a_unmapped_read_zero: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && !mapped(reg_addr) |=> reg_rdata == 16'h0000)
    else $error("undecoded read not zero");

  // status word writes keep only the priority bits
  a_status_write_lands: assert property (@(posedge core_clk) disable iff (reset)
    reg_wr && reg_addr == CMP_STATUS_OFS |=>
    priority_level_low_q == $past(reg_wdata[7:5]))
    else $error("status priority write lost");

  // status reads place the priority bits at 7..5
  a_status_readback: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_addr == CMP_STATUS_OFS |=>
    reg_rdata == {8'h00, $past(priority_level_low_q), 5'h00})
    else $error("status priority readback wrong");

  // frame turned on, then a stack access goes flat
  a_frame_then_stack: assert property (@(posedge core_clk) disable iff (reset)
    s_frame_on ##1 s_stack_access |=> data_flat)
    else $error("stack access paged after frame on");

  // flat stack accesses never carry a page
  a_flat_ignores_pages: assert property (@(posedge core_clk) disable iff (reset)
    ea_is_stack && stack_frame_active && ea_in[15] |=> data_addr[23:16] == 8'h00)
    else $error("page applied to flat stack access");

  // only stack accesses may be flat
  a_flat_only_stack: assert property (@(posedge core_clk) disable iff (reset)
    !ea_is_stack |=> !data_flat)
    else $error("plain access marked flat");

  // paged reads take the read page
  a_paged_read_addr: assert property (@(posedge core_clk) disable iff (reset)
    !ea_is_write && ea_in[15] && !(ea_is_stack && stack_frame_active) |=>
    data_addr == {$past(data_read_page_q[8:0]), $past(ea_in[14:0])})
    else $error("paged read address wrong");

  // paged writes take the write page
  a_paged_write_addr: assert property (@(posedge core_clk) disable iff (reset)
    ea_is_write && ea_in[15] && !(ea_is_stack && stack_frame_active) |=>
    data_addr == {$past(data_write_page_q[8:0]), $past(ea_in[14:0])})
    else $error("paged write address wrong");

  // the lower half of data space is never paged
  a_base_space_addr: assert property (@(posedge core_clk) disable iff (reset)
    !ea_in[15] |=> data_addr == {8'h00, $past(ea_in)})
    else $error("base space address wrong");

  // table reads address through the table page
  a_table_addr_form: assert property (@(posedge core_clk) disable iff (reset)
    pgm_table_read |=> pgm_addr == {$past(table_page_q), $past(table_offset)})
    else $error("table address wrong");

  // table reads with the page bit set reach the identification area
  a_table_id_allowed: assert property (@(posedge core_clk) disable iff (reset)
    pgm_table_read && table_page_q[CMP_TBL_ID_BIT] |=> pgm_allowed)
    else $error("identification table read refused");

  // counter addresses in the lower half are allowed
  a_lower_half_allowed: assert property (@(posedge core_clk) disable iff (reset)
    !pgm_table_read && !program_counter[22] |=> pgm_allowed)
    else $error("lower half refused");

  // priority raised, then a request is still not taken
  a_prio_high_then_req: assert property (@(posedge core_clk) disable iff (reset)
    s_prio_high_on ##1 s_user_request |=> !irq_take)
    else $error("request taken after priority raised");

  // no request, no take
  a_irq_needs_req: assert property (@(posedge core_clk) disable iff (reset)
    !user_irq_req |=> !irq_take)
    else $error("interrupt taken without request");

  // requests at or below the current level wait
  a_prio_low_blocks: assert property (@(posedge core_clk) disable iff (reset)
    user_irq_req && user_irq_level <= {1'b0, priority_level_low_q} |=> !irq_take)
    else $error("low level request taken");

  // an integer select write switches the multiply mode
  a_int_switch: assert property (@(posedge core_clk) disable iff (reset)
    s_int_on |=> int_mode)
    else $error("integer mode not selected");

  // biased rounding takes an exact half upward
  a_round_biased_half: assert property (@(posedge core_clk) disable iff (reset)
    rounding_select && lo_word == 16'h8000 |=> mul_rounded == $past(hi_word) + 16'h0001)
    else $error("biased half not rounded up");

  // convergent rounding leaves an exact half even
  a_round_even_half: assert property (@(posedge core_clk) disable iff (reset)
    !rounding_select && lo_word == 16'h8000 |=> !mul_rounded[0])
    else $error("convergent half not even");

  // below half always truncates
  a_round_below_half: assert property (@(posedge core_clk) disable iff (reset)
    lo_word < 16'h8000 |=> mul_rounded == $past(hi_word))
    else $error("below half rounded up");
endmodule
`default_nettype wire

// *** cmp_pkg.sv ***
// Purpose: constants for the core mode and program space block
// Assumes: 16-bit register port, 50 MHz core clock
// Notes: the core control register is reached at a single chosen offset
// Operation
// - frame set: stack pointers address flat 64K
// - frame clear: stack pointers in the upper half follow page registers
// - rounding select one: biased conventional rounding
// - rounding select zero: convergent round-half-even
// - multiplier select one: integer multiply
// - multiplier select zero: signed fractional multiply
// - priority level is high bit over status bits
// - high priority bit blocks all user interrupts
// - program and data spaces separate, program readable
// - 24-bit program address from 23-bit counter
// - user accesses confined to lower program half
// - table reads with page bit 7 reach identification
package cmp_pkg;
  localparam logic [7:0] CMP_CORE_CONTROL_OFS = 8'h44; // chosen offset
  localparam logic [7:0] CMP_STATUS_OFS = 8'h42; // chosen offset
  localparam logic [7:0] CMP_TABLE_PAGE_OFS = 8'h54; // chosen offset
  localparam logic [7:0] CMP_READ_PAGE_OFS = 8'h32; // chosen offset
  localparam logic [7:0] CMP_WRITE_PAGE_OFS = 8'h34; // chosen offset
  localparam int CMP_INT_MODE_BIT = 0; // multiplier mode bit
  localparam int CMP_ROUND_SEL_BIT = 1; // rounding select bit
  localparam int CMP_FRAME_BIT = 2; // stack frame active bit
  localparam int CMP_PLH_BIT = 3; // priority level high bit
  localparam int CMP_TBL_ID_BIT = 7; // table page identification bit
  localparam logic [15:0] CMP_CORE_CONTROL_RST = 16'h0000; // reset value
  localparam logic [2:0] CMP_PRIO_LOW_RST = 3'h0; // status priority bits after reset
  localparam logic [7:0] CMP_TABLE_PAGE_RST = 8'h00; // table page after reset
  localparam logic [9:0] CMP_PAGE_RST = 10'h001; // data page registers after reset
  localparam logic [15:0] CMP_CORE_CONTROL_WMASK = 16'h000f; // writable bits
  localparam logic [15:0] CMP_FLAT_MAX = 16'hffff; // top of flat range
  localparam logic [23:0] CMP_USER_LIMIT = 24'h7fffff; // top of user half
endpackage

// *** core_mode_and_program_space_bench.sv ***
// Purpose: self-checking bench for the core mode and program space block
// Assumes: every output settles one cycle after the inputs that cause it
// Notes: a shadow model predicts each output; checks run on the falling edge
`timescale 1ns/100ps
`default_nettype none
module core_mode_and_program_space_bench;
  import cmp_pkg::*;
  logic core_clk = 0; // 50 MHz core clock
  logic reset = 1; // held for 12 cycles
  logic [7:0] reg_addr = 0; // register port address
  logic [15:0] reg_wdata = 0, ea_in = 0, table_offset = 0;
  logic reg_wr = 0, reg_rd = 0, ea_is_stack = 0, ea_is_write = 0;
  logic pgm_table_read = 0, user_irq_req = 0;
  logic [3:0] user_irq_level = 0;
  logic [22:0] program_counter = 0;
  logic signed [15:0] mul_a = 0, mul_b = 0;
  logic [15:0] reg_rdata, mul_rounded; // design outputs
  logic [23:0] data_addr, pgm_addr;
  logic data_flat, pgm_allowed, irq_take;
  logic [3:0] cpu_priority;
  logic signed [31:0] mul_product;
  int n_errors = 0, n_compared = 0;
  logic [15:0] ctl = 0, stat = 0, rpg = 1, wpg = 1, tpg = 0; // shadow registers
  logic [15:0] e_rd, e_rn, pg, lo, hi; // expectations for the next cycle
  logic [23:0] e_da, e_pa;
  logic e_fl, e_ok, e_it, have = 0;
  logic [3:0] e_cp;
  logic signed [31:0] prod;
  logic [7:0] adr [8] = '{CMP_CORE_CONTROL_OFS, CMP_STATUS_OFS, CMP_READ_PAGE_OFS,
    CMP_WRITE_PAGE_OFS, 8'h10, CMP_TABLE_PAGE_OFS, CMP_CORE_CONTROL_OFS, 8'h10};
  always #10 core_clk = ~core_clk;
  cmp_core_mode dut (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ea_in, .ea_is_stack, .ea_is_write, .data_addr, .data_flat,
    .program_counter, .pgm_table_read, .table_offset, .pgm_addr, .pgm_allowed,
    .user_irq_req, .user_irq_level, .irq_take, .cpu_priority, .mul_a, .mul_b,
    .mul_product, .mul_rounded);
  // one comparison, counted; an unknown bit matches only an unknown in the same bit
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one compare task for each kind of result
  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    chk(nm, e, g);
  endtask
  task chk_addr(input string nm, input logic [31:0] e, input logic [31:0] g);
    chk(nm, e, g);
  endtask
  task chk_irq(input string nm, input logic [31:0] e, input logic [31:0] g);
    chk(nm, e, g);
  endtask
  task chk_mul(input string nm, input logic [31:0] e, input logic [31:0] g);
    chk(nm, e, g);
  endtask
  // verdict and end of run
  task wrap_up;
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // check last prediction, predict from held inputs, then apply writes
  always @(negedge core_clk) if (!reset) begin
    if (have) begin
      chk_reg("reg_rdata", e_rd, reg_rdata);
      chk_addr("data_flat", e_fl, data_flat);
      chk_addr("data_addr", e_da, data_addr);
      chk_addr("pgm_addr", e_pa, pgm_addr);
      chk_addr("pgm_allowed", e_ok, pgm_allowed);
      chk_irq("cpu_priority", e_cp, cpu_priority);
      chk_irq("irq_take", e_it, irq_take);
      chk_mul("mul_product", prod, mul_product);
      chk_mul("mul_rounded", e_rn, mul_rounded);
    end
    have = 1;
    e_rd = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        CMP_CORE_CONTROL_OFS: e_rd = ctl;
        CMP_STATUS_OFS: e_rd = {8'h00, stat[7:5], 5'h00};
        CMP_TABLE_PAGE_OFS: e_rd = {8'h00, tpg[7:0]};
        CMP_READ_PAGE_OFS: e_rd = {6'h00, rpg[9:0]};
        CMP_WRITE_PAGE_OFS: e_rd = {6'h00, wpg[9:0]};
        default: ;
      endcase
    end
    e_fl = ea_is_stack && ctl[2];
    pg = ea_is_write ? wpg : rpg;
    e_da = (!e_fl && ea_in[15]) ? {pg[8:0], ea_in[14:0]} : {8'h00, ea_in};
    e_pa = pgm_table_read ? {tpg[7:0], table_offset} : {program_counter, 1'b0};
    e_ok = e_pa <= CMP_USER_LIMIT || (pgm_table_read && tpg[7]);
    e_cp = {ctl[3], stat[7:5]};
    e_it = user_irq_req && !ctl[3] && user_irq_level > {1'b0, stat[7:5]};
    prod = mul_a * mul_b;
    if (!ctl[0]) prod = prod <<< 1; // fractional mode drops the extra sign bit
    lo = prod[15:0];
    hi = prod[31:16];
    // exact half: biased rounds up, convergent rounds to even
    e_rn = hi + ((lo > 16'h8000 || (lo == 16'h8000 && (ctl[1] || hi[0]))) ? 16'h1 : 16'h0);
    if (reg_wr) begin
      case (reg_addr)
        CMP_CORE_CONTROL_OFS: ctl = reg_wdata & CMP_CORE_CONTROL_WMASK;
        CMP_STATUS_OFS: stat = reg_wdata;
        CMP_READ_PAGE_OFS: rpg = reg_wdata;
        CMP_WRITE_PAGE_OFS: wpg = reg_wdata;
        CMP_TABLE_PAGE_OFS: tpg = reg_wdata;
        default: ;
      endcase
    end
  end
  // random traffic on every input, strobes never together
  initial begin
    int op;
    op = $urandom(76);
    repeat (12) @(posedge core_clk);
    reset <= 0;
    repeat (4000) begin
      @(posedge core_clk);
      op = $urandom % 8;
      reg_wr <= op < 6;
      reg_rd <= op > 5;
      reg_addr <= (op < 6) ? adr[op] : adr[$urandom % 8];
      reg_wdata <= $urandom;
      ea_in <= $urandom;
      ea_is_stack <= $urandom;
      ea_is_write <= $urandom;
      program_counter <= $urandom;
      pgm_table_read <= $urandom;
      table_offset <= $urandom;
      user_irq_req <= $urandom;
      user_irq_level <= $urandom;
      mul_a <= ($urandom % 4 == 0) ? 16'h0080 : 16'($urandom);
      mul_b <= ($urandom % 2) ? 16'h0300 : 16'($urandom); // halfway cases in integer mode
    end
    @(negedge core_clk);
    #1;
    wrap_up();
  end
endmodule
`default_nettype wire
